// ===== verilog/sdtc_pkg.sv
`default_nettype none
package sdtc_pkg;
  // clock and wall-clock derived counts
  localparam int CLK_KHZ        = 10000;
  localparam int CLK_NS         = 100;
  localparam int INIT_WAIT_US   = 100;
  localparam int INIT_CYCLES    = INIT_WAIT_US * CLK_KHZ / 1000;
  localparam int REF_PERIOD_MS  = 64;
  localparam int REF_COUNT      = 4096;
  localparam int REF_INTERVAL   = REF_PERIOD_MS * CLK_KHZ / REF_COUNT;
  localparam int INIT_REFRESHES = 2;

  // device timing in clock cycles, except CKA_NS in nanoseconds
  localparam int T_MCD    = 2;
  localparam int T_RCD    = 3;
  localparam int T_RAS    = 6;
  localparam int T_RP     = 3;
  localparam int T_RC     = 10;
  localparam int T_RRD    = 2;
  localparam int T_DPL    = 2;
  localparam int T_DAL    = 5;
  localparam int CAS_LAT  = 3;
  localparam int CKA_NS   = 3;
  localparam int T_CKA    = 1 + (CKA_NS + CLK_NS - 1) / CLK_NS;
  localparam int RW_GAP   = (T_RC - T_RCD > T_DAL) ? (T_RC - T_RCD) : T_DAL;

  // widths and address layout
  localparam int ADDR_W   = 12;
  localparam int ROW_W    = 11;
  localparam int COL_W    = 10;
  localparam int DQ_W     = 16;
  localparam int DQM_W    = 2;
  localparam int WAIT_W   = 11;
  localparam int REFC_W   = 8;
  localparam int BANK_BIT = 11;
  localparam int AP_BIT   = 10;
  localparam int BUF_DEPTH = 2;
  localparam logic [ADDR_W-1:0] ADDR_PALL = ADDR_W'(1) << AP_BIT;
  // burst length one, sequential, cas latency three, burst write
  localparam logic [ADDR_W-1:0] MODE_WORD = 12'h030;

  // {ras_n, cas_n, we_n} encodings
  localparam logic [2:0] CMD_MRS   = 3'h0;
  localparam logic [2:0] CMD_REF   = 3'h1;
  localparam logic [2:0] CMD_PRE   = 3'h2;
  localparam logic [2:0] CMD_ACT   = 3'h3;
  localparam logic [2:0] CMD_WRITE = 3'h4;
  localparam logic [2:0] CMD_READ  = 3'h5;
  localparam logic [2:0] CMD_BST   = 3'h6;
  localparam logic [2:0] CMD_NOP   = 3'h7;

  typedef enum logic [7:0] {
    ST_WAIT = 8'h01,
    ST_PALL = 8'h02,
    ST_IREF = 8'h04,
    ST_MRS  = 8'h08,
    ST_IDLE = 8'h10,
    ST_RW   = 8'h20,
    ST_SREF = 8'h40,
    ST_PDN  = 8'h80
  } sdtc_state_e;

  // wait count that puts the next command g cycles after this one
  function automatic logic [WAIT_W-1:0] gap(input int g);
    return WAIT_W'(g - 2);
  endfunction
endpackage
`default_nettype wire

// ===== verilog/sdtc_stream_if.sv
`default_nettype none
interface sdtc_stream_if
  import sdtc_pkg::*;
();
  // word stream with valid and ready
  logic            valid;
  logic            ready;
  logic [DQ_W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// ===== verilog/sdtc_buf2.sv
`default_nettype none
module sdtc_buf2
  import sdtc_pkg::*;
(
  input wire logic   clock,
  input wire logic   rst,
  sdtc_stream_if.snk in_s,
  sdtc_stream_if.src out_s
);
  logic [DQ_W-1:0] mem_q [BUF_DEPTH];
  logic            wr_ptr_q;
  logic            rd_ptr_q;
  logic [1:0]      count_q;
  logic [1:0]      count_d;
  wire             push;
  wire             pop;

  // handshakes and occupancy
  assign push        = in_s.valid && in_s.ready;
  assign pop         = out_s.valid && out_s.ready;
  assign in_s.ready  = count_q != 2'(BUF_DEPTH);
  assign out_s.valid = count_q != 2'h0;
  assign out_s.data  = mem_q[rd_ptr_q];
  assign count_d     = (push && !pop) ? count_q + 2'h1 :
                       (!push && pop) ? count_q - 2'h1 : count_q;

  // pointers and count
  always_ff @(posedge clock) begin
    if (rst) begin
      wr_ptr_q <= 1'b0;
      rd_ptr_q <= 1'b0;
      count_q  <= 2'h0;
    end else begin
      if (push) wr_ptr_q <= ~wr_ptr_q;
      if (pop) rd_ptr_q <= ~rd_ptr_q;
      count_q <= count_d;
    end
  end

  // storage
  always_ff @(posedge clock) begin
    if (push) mem_q[wr_ptr_q] <= in_s.data;
  end
endmodule
`default_nettype wire

// ===== verilog/sdtc_ctrl.sv
// How it works
// - mode set issued once, after power-on wait, with both banks precharged
// - the next command comes two cycles after a mode set
// - read or write comes three cycles after activate; read data six after it
// - activate waits three cycles after any precharge
// - a bank stays active six cycles before it is precharged
// - activates to one bank and refreshes are ten cycles apart
// - activates to different banks are ten cycles apart too; one access runs at a time
// - write data is driven in the write command cycle
// - activate or refresh waits seven cycles after an auto-precharged write, the five of write recovery included
// - one refresh every 64 ms divided by 4096
// - self refresh is refresh with clock enable falling; exit waits a row cycle
// - power-down by clock enable low; left in time for refresh, then recovery
`default_nettype none
module sdtc_ctrl
  import sdtc_pkg::*;
(
  input  wire logic              clock,
  input  wire logic              rst,
  input  wire logic              req_valid,
  output logic                   req_ready,
  input  wire logic              req_write,
  input  wire logic              req_bank,
  input  wire logic [ROW_W-1:0]  req_row,
  input  wire logic [COL_W-1:0]  req_col,
  input  wire logic [DQ_W-1:0]   req_wdata,
  input  wire logic [DQM_W-1:0]  req_wmask,
  output logic                   rd_valid,
  input  wire logic              rd_ready,
  output logic [DQ_W-1:0]        rd_data,
  input  wire logic              selfref_req,
  input  wire logic              pdown_req,
  output logic                   init_done,
  output logic                   sd_cke,
  output logic                   sd_cs_n,
  output logic                   sd_ras_n,
  output logic                   sd_cas_n,
  output logic                   sd_we_n,
  output logic [ADDR_W-1:0]      sd_addr,
  output logic [DQM_W-1:0]       sd_dqm,
  output logic [DQ_W-1:0]        sd_dq_out,
  output logic                   sd_dq_oe,
  input  wire logic [DQ_W-1:0]   sd_dq_in
);
  // sequencer state and registered pin values
  sdtc_state_e         state_q, state_d;
  sdtc_state_e         ret_q, ret_d;
  logic [WAIT_W-1:0]   wait_q, wait_d;
  logic [2:0]          cmd_q, cmd_d;
  logic [ADDR_W-1:0]   addr_q, addr_d;
  logic                cke_q, cke_d;
  logic                cs_n_q;
  logic [DQ_W-1:0]     dq_q, dq_d;
  logic                oe_q, oe_d;
  logic [DQM_W-1:0]    dqm_q, dqm_d;
  // refresh and init bookkeeping
  logic [1:0]          iref_q;
  logic [REFC_W-1:0]   ref_cnt_q;
  logic                ref_pend_q;
  // accepted request and read capture
  logic                wr_q;
  logic                bank_q;
  logic [COL_W-1:0]    col_q;
  logic [DQ_W-1:0]     wdata_q;
  logic [DQM_W-1:0]    wmask_q;
  logic [CAS_LAT-1:0]  rd_pipe_q;
  logic                cap_valid_q;
  logic [DQ_W-1:0]     cap_q;
  logic                init_done_q;
  // sequencer strobes and decoded conditions
  logic                ref_clr;
  logic                sref_exit;
  logic                iref_dec;
  logic                take;
  wire                 ref_tick;
  wire                 ref_pend_d;
  wire                 idle_free;

  // capture side and user side of the read buffer
  sdtc_stream_if cap_if ();
  sdtc_stream_if rd_if ();

  // read words wait here while the receiver stalls
  sdtc_buf2 u_buf (
    .clock (clock),
    .rst   (rst),
    .in_s  (cap_if),
    .out_s (rd_if)
  );

  // buffer hookup and user side
  assign cap_if.valid = cap_valid_q;
  assign cap_if.data  = cap_q;
  assign rd_if.ready  = rd_ready;
  assign rd_valid     = rd_if.valid;
  assign rd_data      = rd_if.data;
  assign init_done    = init_done_q;
  assign idle_free    = (state_q == ST_IDLE) && !ref_pend_q && !selfref_req && !pdown_req;
  assign req_ready    = idle_free && (req_write || cap_if.ready);

  // pins straight from flops
  assign sd_cke    = cke_q;
  assign sd_cs_n   = cs_n_q;
  assign sd_ras_n  = cmd_q[2];
  assign sd_cas_n  = cmd_q[1];
  assign sd_we_n   = cmd_q[0];
  assign sd_addr   = addr_q;
  assign sd_dqm    = dqm_q;
  assign sd_dq_out = dq_q;
  assign sd_dq_oe  = oe_q;

  // refresh interval divider; a new due flag beats its clear
  assign ref_tick   = ref_cnt_q == '0;
  assign ref_pend_d = ref_tick || sref_exit || (ref_pend_q && !ref_clr);

  // command sequencer
  always_comb begin
    state_d   = state_q;
    ret_d     = ret_q;
    wait_d    = wait_q;
    cmd_d     = CMD_NOP;
    addr_d    = addr_q;
    cke_d     = cke_q;
    dq_d      = dq_q;
    oe_d      = 1'b0;
    dqm_d     = '0;
    ref_clr   = 1'b0;
    sref_exit = 1'b0;
    iref_dec  = 1'b0;
    take      = 1'b0;
    case (state_q)
      // count down, then go where the last command asked
      ST_WAIT: begin
        if (wait_q == '0) state_d = ret_q;
        else wait_d = wait_q - WAIT_W'(1);
      end
      // close both banks before the init refreshes
      ST_PALL: begin
        cmd_d   = CMD_PRE;
        addr_d  = ADDR_PALL;
        state_d = ST_WAIT;
        wait_d  = gap(T_RP);
        ret_d   = ST_IREF;
      end
      // init refreshes, a row cycle apart
      ST_IREF: begin
        cmd_d    = CMD_REF;
        iref_dec = 1'b1;
        state_d  = ST_WAIT;
        wait_d   = gap(T_RC);
        ret_d    = (iref_q == 2'h1) ? ST_MRS : ST_IREF;
      end
      // load the mode word, then let it settle
      ST_MRS: begin
        cmd_d   = CMD_MRS;
        addr_d  = MODE_WORD;
        state_d = ST_WAIT;
        wait_d  = gap(T_MCD);
        ret_d   = ST_IDLE;
      end
      // refresh first, then low power, then a new access
      ST_IDLE: begin
        if (ref_pend_q) begin
          cmd_d   = CMD_REF;
          ref_clr = 1'b1;
          state_d = ST_WAIT;
          wait_d  = gap(T_RC);
          ret_d   = ST_IDLE;
        end else if (selfref_req) begin
          cmd_d   = CMD_REF;
          cke_d   = 1'b0;
          state_d = ST_SREF;
        end else if (pdown_req) begin
          cke_d   = 1'b0;
          state_d = ST_PDN;
        end else if (req_valid && req_ready) begin
          take    = 1'b1;
          cmd_d   = CMD_ACT;
          addr_d  = {req_bank, req_row};
          state_d = ST_WAIT;
          wait_d  = gap(T_RCD);
          ret_d   = ST_RW;
        end
      end
      // column command with auto-precharge; closed page
      ST_RW: begin
        cmd_d   = wr_q ? CMD_WRITE : CMD_READ;
        addr_d  = {bank_q, 1'b1, col_q};
        if (wr_q) begin
          dq_d  = wdata_q;
          oe_d  = 1'b1;
          dqm_d = wmask_q;
        end
        state_d = ST_WAIT;
        wait_d  = gap(RW_GAP);
        ret_d   = ST_IDLE;
      end
      // hold clock enable low until the request drops
      ST_SREF: begin
        if (!selfref_req) begin
          cke_d     = 1'b1;
          sref_exit = 1'b1;
          state_d   = ST_WAIT;
          wait_d    = gap(T_RC);
          ret_d     = ST_IDLE;
        end
      end
      // wake for a due refresh or a dropped request
      ST_PDN: begin
        if (!pdown_req || ref_pend_q) begin
          cke_d   = 1'b1;
          state_d = ST_WAIT;
          wait_d  = gap(T_CKA);
          ret_d   = ST_IDLE;
        end
      end
      // an illegal code falls back to idle
      default: state_d = ST_IDLE;
    endcase
  end

  // sequencer and pin registers
  always_ff @(posedge clock) begin
    if (rst) begin
      state_q <= ST_WAIT;
      ret_q   <= ST_PALL;
      wait_q  <= gap(INIT_CYCLES);
      cmd_q   <= CMD_NOP;
      addr_q  <= '0;
      cke_q   <= 1'b1;
      cs_n_q  <= 1'b1;
      dq_q    <= '0;
      oe_q    <= 1'b0;
      dqm_q   <= '0;
    end else begin
      state_q <= state_d;
      ret_q   <= ret_d;
      wait_q  <= wait_d;
      cmd_q   <= cmd_d;
      addr_q  <= addr_d;
      cke_q   <= cke_d;
      cs_n_q  <= 1'b0;
      dq_q    <= dq_d;
      oe_q    <= oe_d;
      dqm_q   <= dqm_d;
    end
  end

  // refresh bookkeeping and init progress
  always_ff @(posedge clock) begin
    if (rst) begin
      ref_cnt_q   <= REFC_W'(REF_INTERVAL - 1);
      ref_pend_q  <= 1'b0;
      iref_q      <= 2'(INIT_REFRESHES);
      init_done_q <= 1'b0;
    end else begin
      ref_cnt_q  <= ref_tick ? REFC_W'(REF_INTERVAL - 1) : ref_cnt_q - REFC_W'(1);
      ref_pend_q <= ref_pend_d;
      if (iref_dec) iref_q <= iref_q - 2'h1;
      if (state_q == ST_IDLE) init_done_q <= 1'b1;
    end
  end

  // accepted request held for the column command
  always_ff @(posedge clock) begin
    if (rst) begin
      wr_q    <= 1'b0;
      bank_q  <= 1'b0;
      col_q   <= '0;
      wdata_q <= '0;
      wmask_q <= '0;
    end else if (take) begin
      wr_q    <= req_write;
      bank_q  <= req_bank;
      col_q   <= req_col;
      wdata_q <= req_wdata;
      wmask_q <= req_wmask;
    end
  end

  // read data captured cas latency after the read reaches the pins
  always_ff @(posedge clock) begin
    if (rst) begin
      rd_pipe_q   <= '0;
      cap_valid_q <= 1'b0;
      cap_q       <= '0;
    end else begin
      rd_pipe_q   <= {rd_pipe_q[CAS_LAT-2:0], cmd_q == CMD_READ};
      cap_valid_q <= rd_pipe_q[CAS_LAT-1];
      if (rd_pipe_q[CAS_LAT-1]) cap_q <= sd_dq_in;
    end
  end
endmodule
`default_nettype wire

// ===== dv/sdtc_ctrl_monitor.sv
`default_nettype none
module sdtc_ctrl_monitor
  import sdtc_pkg::*;
(
  input wire logic              clock,
  input wire logic              rst,
  input wire logic              req_valid,
  input wire logic              req_ready,
  input wire logic              req_bank,
  input wire logic [ROW_W-1:0]  req_row,
  input wire logic [DQ_W-1:0]   req_wdata,
  input wire logic [DQM_W-1:0]  req_wmask,
  input wire logic              init_done,
  input wire logic              sd_cke,
  input wire logic              sd_cs_n,
  input wire logic              sd_ras_n,
  input wire logic              sd_cas_n,
  input wire logic              sd_we_n,
  input wire logic [ADDR_W-1:0] sd_addr,
  input wire logic [DQM_W-1:0]  sd_dqm,
  input wire logic [DQ_W-1:0]   sd_dq_out,
  input wire logic              sd_dq_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // command decode from the pins
  wire [2:0] cmd    = {sd_ras_n, sd_cas_n, sd_we_n};
  wire       issued = !sd_cs_n && cmd != CMD_NOP;
  wire       act    = issued && cmd == CMD_ACT;
  wire       pre    = issued && cmd == CMD_PRE;
  wire       refc   = issued && cmd == CMD_REF;
  wire       mrs    = issued && cmd == CMD_MRS;
  wire       wr     = issued && cmd == CMD_WRITE;
  wire       rw     = wr || (issued && cmd == CMD_READ);
  wire       take   = req_valid && req_ready;
  logic [DQ_W-1:0]  wd_q;
  logic [DQM_W-1:0] wm_q;
  // word and mask of the accepted request
  always_ff @(posedge clock) begin
    if (take) begin
      wd_q <= req_wdata;
      wm_q <= req_wmask;
    end
  end
  chk_mrs_gap: assert property (mrs |=> !issued)
    else $error("command too soon after mode set");
  chk_act_rcd: assert property (act |=> !rw [*2])
    else $error("column command too soon after activate");
  chk_act_rc: assert property (act |=> !act [*8] ##1 !act)
    else $error("activates too close");
  chk_ref_rc: assert property (refc |=> !issued [*8] ##1 !issued)
    else $error("command during refresh period");
  chk_pre_rp: assert property (pre |=> !act [*2])
    else $error("activate too soon after precharge");
  chk_ras_min: assert property (act |=> !pre [*5])
    else $error("precharge too soon after activate");
  chk_wr_data: assert property (wr |-> sd_dq_oe && sd_dq_out == wd_q && sd_dqm == wm_q)
    else $error("write word or mask not driven with write");
  chk_dal_gap: assert property (wr |=> !(act || refc) [*5])
    else $error("write recovery too short");
  chk_take_act: assert property (take |=> act && sd_addr[BANK_BIT] == $past(req_bank)
    && sd_addr[ROW_W-1:0] == $past(req_row))
    else $error("activate does not follow request");
  chk_cke_wake: assert property ($rose(sd_cke) |=> !issued)
    else $error("command right after clock enable rise");
  chk_ready_init: assert property (req_ready |-> init_done)
    else $error("request accepted before init");
  cover property (wr);
  cover property (refc && !sd_cke);
  cover property ($rose(sd_cke));
endmodule
bind sdtc_ctrl sdtc_ctrl_monitor u_mon (.clock, .rst, .req_valid, .req_ready, .req_bank,
  .req_row, .req_wdata, .req_wmask, .init_done, .sd_cke, .sd_cs_n, .sd_ras_n, .sd_cas_n,
  .sd_we_n, .sd_addr, .sd_dqm, .sd_dq_out, .sd_dq_oe);
`default_nettype wire

// ===== dv/sdtc_sdram_model.sv
`default_nettype none
module sdtc_sdram_model
  import sdtc_pkg::*;
(
  input wire logic              clock,
  input wire logic              cke,
  input wire logic              cs_n,
  input wire logic              ras_n,
  input wire logic              cas_n,
  input wire logic              we_n,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DQM_W-1:0]  dqm,
  input wire logic [DQ_W-1:0]   dq_out,
  input wire logic              dq_oe,
  output logic [DQ_W-1:0]       dq_in,
  output int                    n_ref,
  output int                    n_sref,
  output int                    n_mrs,
  output int                    n_bad,
  output logic [ADDR_W-1:0]     mode_q
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [DQ_W-1:0]  mem [int];
  logic [1:0]       open_q = 2'h0;
  logic [ROW_W-1:0] row_q [2];
  logic [1:0]       cnt_q = 2'h0;
  logic [DQ_W-1:0]  rd_q;
  logic [DQ_W-1:0]  last_q = 16'h0000;
  logic [DQ_W-1:0]  old;
  logic             cke_q = 1'b0;
  int               k;
  wire [2:0] cmd = {ras_n, cas_n, we_n};
  wire       b   = addr[BANK_BIT];
  wire       on  = cke_q && !cs_n;
  // wire level: controller, device word, else inverse of last level
  assign dq_in = dq_oe ? dq_out : (cnt_q == 2'h1) ? rd_q : ~last_q;
  initial begin
    n_ref = 0;
    n_sref = 0;
    n_mrs = 0;
    n_bad = 0;
  end
  // command execution at the rising edge
  always @(posedge clock) begin
    cke_q <= cke;
    last_q <= dq_in;
    if (cnt_q != 2'h0) cnt_q <= cnt_q - 2'h1;
    k = int'({b, row_q[b], addr[COL_W-1:0]});
    if (on) begin
      case (cmd)
        CMD_MRS: begin
          mode_q <= addr;
          n_mrs++;
          if (open_q != 2'h0) n_bad++;
        end
        CMD_REF: begin
          if (open_q != 2'h0) n_bad++;
          if (cke) n_ref++;
          else n_sref++;
        end
        CMD_PRE: open_q <= addr[AP_BIT] ? 2'h0 : open_q & ~(2'h1 << b);
        CMD_ACT: begin
          if (open_q[b]) n_bad++;
          open_q[b] <= 1'b1;
          row_q[b] <= addr[ROW_W-1:0];
        end
        CMD_READ, CMD_WRITE: begin
          if (!open_q[b]) n_bad++;
          if (addr[AP_BIT]) open_q[b] <= 1'b0;
          old = mem.exists(k) ? mem[k] : 16'h0000;
          if (cmd == CMD_READ) begin
            rd_q <= old;
            cnt_q <= 2'h3;
          end else begin
            mem[k] = {dqm[1] ? old[15:8] : dq_in[15:8], dqm[0] ? old[7:0] : dq_in[7:0]};
          end
        end
        default: ;
      endcase
    end
  end
endmodule
`default_nettype wire

// ===== dv/tb_sdtc_ctrl.sv
`default_nettype none
module tb_sdtc_ctrl
  import sdtc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic w; logic b; logic [ROW_W-1:0] r; logic [COL_W-1:0] c;
    logic [DQ_W-1:0] d; logic [DQM_W-1:0] m; logic [DQ_W-1:0] e;
  } sdtc_row_s;
  logic clock = 1'b0, rst = 1'b1, req_valid = 1'b0, req_write = 1'b0, req_bank = 1'b0;
  logic rd_ready = 1'b0, selfref_req = 1'b0, pdown_req = 1'b0, flag;
  logic [ROW_W-1:0] req_row = '0;
  logic [COL_W-1:0] req_col = '0;
  logic [DQ_W-1:0] req_wdata = '0, rd_data, sd_dq_out, sd_dq_in;
  logic [DQM_W-1:0] req_wmask = '0, sd_dqm;
  logic [ADDR_W-1:0] sd_addr, mode;
  logic req_ready, rd_valid, init_done, sd_cke, sd_cs_n, sd_ras_n, sd_cas_n, sd_we_n, sd_dq_oe;
  int n_ref, n_sref, n_mrs, n_bad, k, old, n_mismatch = 0, n_tests = 0;
  sdtc_row_s rows [8] = '{
    '{1'b1, 1'b0, 11'h000, 10'h000, 16'h1234, 2'h0, 16'h0000},
    '{1'b1, 1'b1, 11'h7FF, 10'h3FF, 16'hABCD, 2'h0, 16'h0000},
    '{1'b0, 1'b0, 11'h000, 10'h000, 16'h0000, 2'h0, 16'h1234},
    '{1'b0, 1'b1, 11'h7FF, 10'h3FF, 16'h0000, 2'h0, 16'hABCD},
    '{1'b1, 1'b1, 11'h7FF, 10'h3FF, 16'h5566, 2'h1, 16'h0000},
    '{1'b0, 1'b1, 11'h7FF, 10'h3FF, 16'h0000, 2'h0, 16'h55CD},
    '{1'b1, 1'b0, 11'h123, 10'h0AA, 16'hFFFF, 2'h2, 16'h0000},
    '{1'b0, 1'b0, 11'h123, 10'h0AA, 16'h0000, 2'h0, 16'h00FF}};
  always #50 clock = ~clock;
  sdtc_ctrl dut (.clock, .rst, .req_valid, .req_ready, .req_write, .req_bank, .req_row,
    .req_col, .req_wdata, .req_wmask, .rd_valid, .rd_ready, .rd_data, .selfref_req,
    .pdown_req, .init_done, .sd_cke, .sd_cs_n, .sd_ras_n, .sd_cas_n, .sd_we_n, .sd_addr,
    .sd_dqm, .sd_dq_out, .sd_dq_oe, .sd_dq_in);
  sdtc_sdram_model u_mem (.clock(clock), .cke(sd_cke), .cs_n(sd_cs_n), .ras_n(sd_ras_n),
    .cas_n(sd_cas_n), .we_n(sd_we_n), .addr(sd_addr), .dqm(sd_dqm), .dq_out(sd_dq_out),
    .dq_oe(sd_dq_oe), .dq_in(sd_dq_in), .n_ref(n_ref), .n_sref(n_sref), .n_mrs(n_mrs),
    .n_bad(n_bad), .mode_q(mode));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    if (n_mismatch == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // raise a request held until taken
  task automatic post(input sdtc_row_s x);
    @(posedge clock);
    req_valid <= 1'b1;
    req_write <= x.w;
    req_bank <= x.b;
    req_row <= x.r;
    req_col <= x.c;
    req_wdata <= x.d;
    req_wmask <= x.m;
  endtask
  task automatic take();
    int n;
    n = 0;
    @(negedge clock);
    while (req_ready !== 1'b1 && n < 3000) begin
      @(negedge clock);
      n++;
    end
    if (n >= 3000) n_mismatch++;
    @(posedge clock);
    req_valid <= 1'b0;
  endtask
  task automatic pop(input logic [15:0] e);
    int n;
    n = 0;
    @(posedge clock);
    rd_ready <= 1'b1;
    @(negedge clock);
    while (rd_valid !== 1'b1 && n < 200) begin
      @(negedge clock);
      n++;
    end
    if (n >= 200) n_mismatch++;
    check(rd_data, e);
    @(posedge clock);
    rd_ready <= 1'b0;
  endtask
  task automatic cke_low();
    int n;
    n = 0;
    @(negedge clock);
    while (sd_cke !== 1'b0 && n < 400) begin
      @(negedge clock);
      n++;
    end
    check({15'h0, sd_cke}, 16'h0000);
  endtask
  // main sequence
  initial begin
    repeat (7) @(posedge clock);
    @(negedge clock);
    check({11'h0, sd_cs_n, sd_cke, req_ready, rd_valid, init_done}, 16'h0018);
    @(posedge clock);
    rst <= 1'b0;
    for (k = 0; k < 8; k++) begin
      post(rows[k]);
      take();
      if (!rows[k].w) pop(rows[k].e);
    end
    check({4'h0, mode}, {4'h0, MODE_WORD});
    check(n_mrs[15:0], 16'h0001);
    post(rows[5]);
    take();
    post(rows[2]);
    take();
    post(rows[7]);
    flag = 1'b0;
    repeat (30) begin
      @(negedge clock);
      flag |= req_ready;
    end
    check({15'h0, flag}, 16'h0000);
    pop(16'h55CD);
    take();
    pop(16'h1234);
    pop(16'h00FF);
    @(posedge clock);
    selfref_req <= 1'b1;
    cke_low();
    repeat (100) @(posedge clock);
    selfref_req <= 1'b0;
    post(rows[7]);
    take();
    pop(16'h00FF);
    check(n_sref[15:0], 16'h0001);
    old = n_ref;
    repeat (REF_INTERVAL + 5) @(posedge clock);
    check(16'(n_ref > old), 16'h0001);
    @(posedge clock);
    pdown_req <= 1'b1;
    cke_low();
    @(posedge clock);
    pdown_req <= 1'b0;
    post(rows[5]);
    take();
    pop(16'h55CD);
    // reset in mid-run: pins and flags return, init runs again
    @(posedge clock);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    @(negedge clock);
    check({11'h0, sd_cs_n, sd_cke, req_ready, rd_valid, init_done}, 16'h0018);
    @(posedge clock);
    rst <= 1'b0;
    post(rows[2]);
    take();
    check({15'h0, init_done}, 16'h0001);
    pop(16'h1234);
    check(n_mrs[15:0], 16'h0002);
    check(n_bad[15:0], 16'h0000);
    conclude();
  end
  // watchdog
  initial begin
    repeat (20000) @(posedge clock);
    n_mismatch++;
    conclude();
  end
endmodule
`default_nettype wire
